// File: shared/otps_map.svh
// constants for the output threshold and pwm scaler
`ifndef OTPS_MAP_SVH
`define OTPS_MAP_SVH
`define OTPS_CLK_NS      20
`define OTPS_TICK_NS     1000000
`define OTPS_PWM_MIN_NS  100000000
`define OTPS_PWM_MIN_TK  (`OTPS_PWM_MIN_NS / `OTPS_TICK_NS)
`define OTPS_TICK_CYC    (`OTPS_TICK_NS / `OTPS_CLK_NS)
`define OTPS_MW          17
`define OTPS_OUT_OFF     1'b0
`define OTPS_OUT_ON      1'b1
`define OTPS_CUR_MIN_UA  16'sh0bb8
`define OTPS_CUR_MAX_UA  16'sh55f0
`define OTPS_T_ZERO      16'h0000
`define OTPS_T_ONE       16'h0001
`define OTPS_T_MAX       16'hffff
`endif

// File: shared/otps_pkg.sv
// types shared by the output threshold and pwm scaler
package otps_pkg;
  typedef enum logic [2:0] {
    OTPS_DISABLED, OTPS_ABOVE, OTPS_BELOW, OTPS_INSIDE, OTPS_OUTSIDE,
    OTPS_PWM
  } otps_mode_e;
  typedef enum logic [2:0] {
    OTPS_NO_CHANGE, OTPS_IMM_OFF, OTPS_IMM_ON, OTPS_TIMED_OFF, OTPS_TIMED_ON
  } otps_react_e;
  typedef enum logic [1:0] {
    OTPS_ST_OK, OTPS_ST_ERROR, OTPS_ST_BELOW_RANGE, OTPS_ST_ABOVE_RANGE
  } otps_status_e;
  typedef logic signed [15:0] otps_val_t;
  typedef logic [15:0]        otps_time_t;
endpackage : otps_pkg

// File: design/otps_lin_map.sv
// clamped linear interpolation between two points
`timescale 1ns/1ps
`include "otps_map.svh"
module otps_lin_map (
  input  wire logic signed [`OTPS_MW-1:0] x,
  input  wire logic signed [`OTPS_MW-1:0] x0,
  input  wire logic signed [`OTPS_MW-1:0] x1,
  input  wire logic signed [`OTPS_MW-1:0] y0,
  input  wire logic signed [`OTPS_MW-1:0] y1,
  output logic signed      [`OTPS_MW-1:0] y
);
  logic signed [`OTPS_MW-1:0]   xc;
  logic signed [`OTPS_MW:0]     dx;
  logic signed [`OTPS_MW:0]     den;
  logic signed [`OTPS_MW:0]     dy;
  logic signed [2*`OTPS_MW+1:0] num;
  logic signed [2*`OTPS_MW+1:0] q;
  logic signed [`OTPS_MW:0]     ys;
  logic signed [`OTPS_MW-1:0]   yLo;
  logic signed [`OTPS_MW-1:0]   yHi;

  // clamp input, scale, then clamp result to the endpoint span
  always_comb begin
    xc = (x < x0) ? x0 : ((x > x1) ? x1 : x);
    dx = (`OTPS_MW+1)'(xc) - (`OTPS_MW+1)'(x0);
    den = (`OTPS_MW+1)'(x1) - (`OTPS_MW+1)'(x0);
    dy = (`OTPS_MW+1)'(y1) - (`OTPS_MW+1)'(y0);
    num = (2*`OTPS_MW+2)'(dx) * (2*`OTPS_MW+2)'(dy);
    // empty span divides by nothing and pins the low endpoint
    q = (den > 0) ? num / (2*`OTPS_MW+2)'(den) : '0;
    ys = (`OTPS_MW+1)'(y0) + q[`OTPS_MW:0];
    yLo = (y0 < y1) ? y0 : y1;
    yHi = (y0 < y1) ? y1 : y0;
    if (ys < (`OTPS_MW+1)'(yLo)) begin
      y = yLo;
    end else if (ys > (`OTPS_MW+1)'(yHi)) begin
      y = yHi;
    end else begin
      y = ys[`OTPS_MW-1:0];
    end
  end
endmodule : otps_lin_map

// File: design/otps_scaler.sv
// output decision: threshold relay, pwm and current scaling
`timescale 1ns/1ps
`include "otps_map.svh"
module otps_scaler
  import otps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `OTPS_TICK_CYC
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire otps_mode_e   outMode,
  input  wire otps_react_e  alarmReact,
  input  wire logic         levelFromChan,
  input  wire otps_val_t    lowerConst,
  input  wire otps_val_t    upperConst,
  input  wire otps_val_t    lowerChan,
  input  wire otps_val_t    upperChan,
  input  wire otps_val_t    hysteresis,
  input  wire otps_val_t    srcValue,
  input  wire otps_status_e srcStatus,
  input  wire otps_time_t   onDelay,
  input  wire otps_time_t   offDelay,
  input  wire otps_time_t   minOnTime,
  input  wire otps_time_t   minOffTime,
  input  wire otps_time_t   pwmPeriod,
  input  wire otps_val_t    pwmAlarmLevel,
  input  wire otps_val_t    inLower,
  input  wire otps_val_t    inUpper,
  input  wire otps_val_t    outLower,
  input  wire otps_val_t    outUpper,
  input  wire otps_val_t    currentAlarm,
  output logic              binOut,
  output otps_val_t         currentOut,
  output logic              alarmActive
);
  localparam otps_time_t PWM_MIN = otps_time_t'(`OTPS_PWM_MIN_TK);
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  logic [31:0] tickCnt_reg, tickCnt_next;
  logic        tick_reg, tick_next;
  logic        out_reg, out_next;
  otps_time_t  delayCnt_reg, delayCnt_next;
  otps_time_t  minCnt_reg, minCnt_next;
  otps_time_t  phase_reg, phase_next;
  otps_val_t   cur_reg, cur_next;
  logic        alarm_reg, alarm_next;

  otps_val_t   bndConst [2];
  otps_val_t   bndChan  [2];
  otps_val_t   bnd      [2];
  logic signed [17:0] s18, lo18, hi18, h18;
  logic        isThr, isAlarm, cond, want, forceNow, forceVal;
  otps_time_t  needDelay, needMin, effPeriod;
  logic signed [`OTPS_MW-1:0] pwmX, duty, curMap;

  assign bndConst[0] = lowerConst;
  assign bndConst[1] = upperConst;
  assign bndChan[0]  = lowerChan;
  assign bndChan[1]  = upperChan;

  // per-bound source selection, constant or live channel
  for (genvar i = 0; i < 2; i++) begin : g_bnd
    assign bnd[i] = levelFromChan ? bndChan[i] : bndConst[i];
  end

  // widened copies so hysteresis shifts cannot wrap
  assign s18  = 18'(srcValue);
  assign lo18 = 18'(bnd[0]);
  assign hi18 = 18'(bnd[1]);
  assign h18  = 18'(hysteresis);
  assign isThr = (outMode != OTPS_DISABLED) && (outMode != OTPS_PWM);
  assign isAlarm = (srcStatus != OTPS_ST_OK);

  // comparison; active state widens the band so it does not chatter
  always_comb begin
    cond = 1'b0;
    case (outMode)
      OTPS_ABOVE: begin
        cond = out_reg ? (s18 > lo18 - h18) : (s18 > lo18 + h18);
      end
      OTPS_BELOW: begin
        cond = out_reg ? (s18 < lo18 + h18) : (s18 < lo18 - h18);
      end
      OTPS_INSIDE: begin
        cond = out_reg ? (s18 >= lo18 - h18 && s18 <= hi18 + h18)
                       : (s18 >= lo18 + h18 && s18 <= hi18 - h18);
      end
      OTPS_OUTSIDE: begin
        cond = out_reg ? (s18 < lo18 + h18 || s18 > hi18 - h18)
                       : (s18 < lo18 - h18 || s18 > hi18 + h18);
      end
      default: cond = 1'b0;
    endcase
  end

  // pwm duty and current mapping each use their own interpolator instance
  assign effPeriod = (pwmPeriod < PWM_MIN) ? PWM_MIN : pwmPeriod;
  assign pwmX = isAlarm ? `OTPS_MW'(pwmAlarmLevel)
                        : `OTPS_MW'(srcValue);

  otps_lin_map u_pwmMap (
    .x  (pwmX),
    .x0 (`OTPS_MW'(bnd[0])),
    .x1 (`OTPS_MW'(bnd[1])),
    .y0 ('0),
    .y1 (`OTPS_MW'({1'b0, effPeriod})),
    .y  (duty)
  );

  otps_lin_map u_curMap (
    .x  (`OTPS_MW'(srcValue)),
    .x0 (`OTPS_MW'(inLower)),
    .x1 (`OTPS_MW'(inUpper)),
    .y0 (`OTPS_MW'(outLower)),
    .y1 (`OTPS_MW'(outUpper)),
    .y  (curMap)
  );

  // desired level and alarm overrides
  always_comb begin
    want = `OTPS_OUT_OFF;
    forceNow = 1'b0;
    forceVal = `OTPS_OUT_OFF;
    needDelay = `OTPS_T_ZERO;
    needMin = out_reg ? minOnTime : minOffTime;
    if (outMode == OTPS_PWM) begin
      want = ({1'b0, phase_reg} < 17'(duty));
    end else if (isThr) begin
      want = cond;
      needDelay = out_reg ? offDelay : onDelay;
      if (isAlarm) begin
        case (alarmReact)
          OTPS_NO_CHANGE: want = out_reg;
          OTPS_IMM_OFF: begin
            forceNow = 1'b1;
            forceVal = `OTPS_OUT_OFF;
          end
          OTPS_IMM_ON: begin
            forceNow = 1'b1;
            forceVal = `OTPS_OUT_ON;
          end
          OTPS_TIMED_OFF: want = `OTPS_OUT_OFF;
          OTPS_TIMED_ON: want = `OTPS_OUT_ON;
          default: want = out_reg;
        endcase
      end
    end
  end

  // tick base: every timer below advances only on this pulse
  always_comb begin
    tick_next = (tickCnt_reg == TICK_LAST);
    tickCnt_next = tick_next ? '0 : tickCnt_reg + 32'h0000_0001;
  end

  // switching engine: delay timer, minimum hold timer, pwm phase
  always_comb begin
    out_next = out_reg;
    delayCnt_next = delayCnt_reg;
    minCnt_next = minCnt_reg;
    phase_next = phase_reg;
    if (outMode == OTPS_DISABLED) begin
      out_next = `OTPS_OUT_OFF;
      delayCnt_next = `OTPS_T_ZERO;
      minCnt_next = `OTPS_T_ZERO;
      phase_next = `OTPS_T_ZERO;
    end else if (forceNow) begin
      out_next = forceVal;
      delayCnt_next = `OTPS_T_ZERO;
      if (forceVal != out_reg) begin
        minCnt_next = `OTPS_T_ZERO;
      end
    end else if (tick_reg) begin
      if (minCnt_reg != `OTPS_T_MAX) begin
        minCnt_next = minCnt_reg + `OTPS_T_ONE;
      end
      if (outMode == OTPS_PWM) begin
        phase_next = (phase_reg >= effPeriod - `OTPS_T_ONE)
                   ? `OTPS_T_ZERO : phase_reg + `OTPS_T_ONE;
      end
      if (want == out_reg) begin
        delayCnt_next = `OTPS_T_ZERO;
      end else if (delayCnt_reg >= needDelay && minCnt_reg >= needMin) begin
        out_next = want;
        delayCnt_next = `OTPS_T_ZERO;
        minCnt_next = `OTPS_T_ZERO;
      end else if (delayCnt_reg != `OTPS_T_MAX) begin
        delayCnt_next = delayCnt_reg + `OTPS_T_ONE;
      end
    end
  end

  // current output; alarm value kept inside the hardware span
  always_comb begin
    alarm_next = isAlarm;
    if (isAlarm) begin
      if (currentAlarm < `OTPS_CUR_MIN_UA) begin
        cur_next = `OTPS_CUR_MIN_UA;
      end else if (currentAlarm > `OTPS_CUR_MAX_UA) begin
        cur_next = `OTPS_CUR_MAX_UA;
      end else begin
        cur_next = currentAlarm;
      end
    end else begin
      cur_next = curMap[15:0];
    end
  end

  // all state registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tickCnt_reg <= '0;
      tick_reg <= 1'b0;
      out_reg <= `OTPS_OUT_OFF;
      delayCnt_reg <= `OTPS_T_ZERO;
      minCnt_reg <= `OTPS_T_ZERO;
      phase_reg <= `OTPS_T_ZERO;
      cur_reg <= `OTPS_CUR_MIN_UA;
      alarm_reg <= 1'b0;
    end else begin
      tickCnt_reg <= tickCnt_next;
      tick_reg <= tick_next;
      out_reg <= out_next;
      delayCnt_reg <= delayCnt_next;
      minCnt_reg <= minCnt_next;
      phase_reg <= phase_next;
      cur_reg <= cur_next;
      alarm_reg <= alarm_next;
    end
  end

  assign binOut = out_reg;
  assign currentOut = cur_reg;
  assign alarmActive = alarm_reg;

  // checks on the switching engine and the current path
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  disabled_off_a: assert property (
    outMode == OTPS_DISABLED |=> binOut == 1'b0)
    else $error("output active while disabled");
  min_on_a: assert property (
    $fell(out_reg) && !$past(forceNow) && $past(outMode) != OTPS_DISABLED
    |-> $past(minCnt_reg) >= $past(minOnTime))
    else $error("output released before minimum on time");
  min_off_a: assert property (
    $rose(out_reg) && !$past(forceNow)
    |-> $past(minCnt_reg) >= $past(minOffTime))
    else $error("output set before minimum off time");
  on_delay_a: assert property (
    $rose(out_reg) && $past(isThr) && !$past(forceNow)
    |-> $past(delayCnt_reg) >= $past(onDelay))
    else $error("switch on before on delay");
  off_delay_a: assert property (
    $fell(out_reg) && $past(isThr) && !$past(forceNow)
    && $past(outMode) != OTPS_DISABLED
    |-> $past(delayCnt_reg) >= $past(offDelay))
    else $error("switch off before off delay");
  pwm_phase_a: assert property (
    outMode == OTPS_PWM |-> phase_reg < effPeriod && effPeriod >= PWM_MIN)
    else $error("pwm phase beyond period");
  imm_force_a: assert property (
    isThr && isAlarm && alarmReact == OTPS_IMM_ON
    ##1 $stable(outMode) |-> binOut)
    else $error("immediate on not applied");
  cur_alarm_a: assert property (
    isAlarm |=> alarmActive && currentOut >= `OTPS_CUR_MIN_UA
            && currentOut <= `OTPS_CUR_MAX_UA)
    else $error("alarm current outside hardware span");
  cur_clamp_a: assert property (
    !isAlarm && outLower <= outUpper && inLower < inUpper
    |=> currentOut >= $past(outLower) && currentOut <= $past(outUpper))
    else $error("current outside output bounds");
  alarm_flag_a: assert property (
    ##1 alarmActive == ($past(srcStatus) != OTPS_ST_OK))
    else $error("alarm flag does not follow source status");

  c_thr_on: cover property (isThr && $rose(out_reg));
  c_pwm_cycle: cover property (outMode == OTPS_PWM && $fell(out_reg));
  c_alarm_cur: cover property ($rose(alarmActive));
  c_timed_on: cover property (isAlarm && alarmReact == OTPS_TIMED_ON
                              && $rose(out_reg));
endmodule : otps_scaler

// File: sim/testbench.sv
// self-checking bench for the output threshold and pwm scaler
`timescale 1ns/1ps
`include "otps_map.svh"
module testbench
  import otps_pkg::*;
();
  localparam int TK = 4;
  logic         core_clk = 1'b0;
  logic         sys_rst = 1'b1;
  otps_mode_e   outMode = OTPS_DISABLED;
  otps_react_e  alarmReact = OTPS_NO_CHANGE;
  logic         levelFromChan = 1'b0;
  otps_status_e srcStatus = OTPS_ST_OK;
  otps_val_t    lowerConst = '0, upperConst = '0, lowerChan = '0;
  otps_val_t    upperChan = '0, hysteresis = '0, srcValue = '0;
  otps_val_t    pwmAlarmLevel = '0, inLower = '0, currentAlarm = '0;
  otps_val_t    inUpper = 16'sh03e8, outLower = 16'sh0fa0;
  otps_val_t    outUpper = 16'sh4e20;
  otps_time_t   onDelay = '0, offDelay = '0, minOnTime = '0;
  otps_time_t   minOffTime = '0, pwmPeriod = 16'h0064;
  otps_val_t    currentOut, lo, hi, s;
  logic         binOut, alarmActive;
  int           nMismatch = 0, testsRun = 0, seed = 32'h02cc0bb4;
  int           hiCnt, rises, minHi, minLo;
  otps_val_t    hsv[5] = '{-16'sh0032, 16'sh0005, 16'sh000f, -16'sh0005,
                           -16'sh000f};
  logic         hse[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  otps_val_t    caIn[3] = '{16'sh61a8, 16'sh03e8, 16'sh1388};
  otps_val_t    caExp[3] = '{`OTPS_CUR_MAX_UA, `OTPS_CUR_MIN_UA, 16'sh1388};

  // short tick keeps delays and pwm periods to a few hundred clocks
  otps_scaler #(.TICK_CYCLES(TK)) dut (
    .core_clk, .sys_rst, .outMode, .alarmReact, .levelFromChan,
    .lowerConst, .upperConst, .lowerChan, .upperChan, .hysteresis,
    .srcValue, .srcStatus, .onDelay, .offDelay, .minOnTime, .minOffTime,
    .pwmPeriod, .pwmAlarmLevel, .inLower, .inUpper, .outLower, .outUpper,
    .currentAlarm, .binOut, .currentOut, .alarmActive
  );

  // 50 mhz clock
  initial begin
    forever #10 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("mismatches %0d of %0d comparisons", nMismatch, testsRun);
    if (nMismatch == 0 && testsRun > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : check

  // waits n edges, then steps past them so outputs are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic put(input otps_mode_e m, input otps_val_t x);
    @(posedge core_clk);
    outMode <= m;
    srcValue <= x;
  endtask : put

  // expected binary decision with no hysteresis
  function automatic logic want(input otps_mode_e m,
                                input otps_val_t x, l, h);
    case (m)
      OTPS_ABOVE:   return x > l;
      OTPS_BELOW:   return x < l;
      OTPS_INSIDE:  return x >= l && x <= h;
      OTPS_OUTSIDE: return x < l || x > h;
      default:      return 1'b0;
    endcase
  endfunction : want

  // clamp to input span, then straight line onto the output span
  function automatic otps_val_t curExp(input otps_val_t x);
    int c;
    c = x < inLower ? inLower : (x > inUpper ? inUpper : x);
    return otps_val_t'(outLower + (c - inLower) * (outUpper - outLower)
                       / (inUpper - inLower));
  endfunction : curExp

  // high count, rising edges and shortest complete runs over n clocks
  task automatic measure(input int n);
    logic prev;
    int   run;
    prev = binOut;
    run = -1;
    hiCnt = 0;
    rises = 0;
    minHi = 99999;
    minLo = 99999;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (binOut !== prev) begin
        if (run >= 0 && prev) minHi = (run < minHi) ? run : minHi;
        if (run >= 0 && !prev) minLo = (run < minLo) ? run : minLo;
        rises += int'(binOut);
        run = 0;
      end
      if (run >= 0) run++;
      hiCnt += int'(binOut);
      prev = binOut;
    end
  endtask : measure

  // two whole periods of 400 clocks give an exact high count at any phase
  task automatic pwmCase(input otps_val_t x, input otps_time_t per,
                         input otps_status_e st, input otps_time_t mOn, mOff,
                         input int eHi, eRise);
    @(posedge core_clk);
    pwmPeriod <= per;
    srcStatus <= st;
    minOnTime <= mOn;
    minOffTime <= mOff;
    put(OTPS_PWM, x);
    cyc(800);
    measure(800);
    if (eHi >= 0) begin
      check(hiCnt, eHi);
      check(rises, eRise);
    end
    check(minHi >= 80, 1'b1);
    check(minLo >= 80, 1'b1);
  endtask : pwmCase

  // hang guard, far beyond the roughly 13k clocks the run needs
  initial begin : watchdog
    #1000000;
    nMismatch++;
    summarize();
  end

  initial begin : main
    cyc(9);
    check(binOut, 1'b0);
    check(currentOut, `OTPS_CUR_MIN_UA);
    check(alarmActive, 1'b0);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    put(OTPS_DISABLED, 16'sh7fff);
    cyc(40);
    check(binOut, 1'b0);
    // random levels; the unused bound pair is swapped to catch a bad select
    for (int i = 0; i < 24; i++) begin
      lo = otps_val_t'($random(seed) % 200 - 200);
      hi = otps_val_t'($random(seed) % 200 + 200);
      s = otps_val_t'($random(seed) % 500);
      if (i < 4) s = lo;
      @(posedge core_clk);
      levelFromChan <= i[2];
      lowerConst <= i[2] ? hi : lo;
      upperConst <= i[2] ? lo : hi;
      lowerChan <= i[2] ? lo : hi;
      upperChan <= i[2] ? hi : lo;
      put(otps_mode_e'(3'(i % 4 + 1)), s);
      cyc(40);
      check(binOut, want(outMode, s, lo, hi));
    end
    @(posedge core_clk);
    levelFromChan <= 1'b0;
    lowerConst <= '0;
    hysteresis <= 16'sh000a;
    foreach (hsv[k]) begin
      put(OTPS_ABOVE, hsv[k]);
      cyc(20);
      check(binOut, hse[k]);
    end
    @(posedge core_clk);
    hysteresis <= '0;
    onDelay <= 16'h0005;
    offDelay <= 16'h0005;
    put(OTPS_ABOVE, 16'sh0032);
    cyc(12);
    check(binOut, 1'b0);
    cyc(30);
    check(binOut, 1'b1);
    put(OTPS_ABOVE, -16'sh0032);
    cyc(12);
    check(binOut, 1'b1);
    cyc(30);
    check(binOut, 1'b0);
    // a broken request must restart the on delay
    put(OTPS_ABOVE, 16'sh0032);
    cyc(12);
    put(OTPS_ABOVE, -16'sh0032);
    cyc(8);
    put(OTPS_ABOVE, 16'sh0032);
    cyc(12);
    check(binOut, 1'b0);
    @(posedge core_clk);
    onDelay <= '0;
    offDelay <= '0;
    // long minimum times are how software keeps a relay from chattering
    minOnTime <= 16'h000a;
    minOffTime <= 16'h0014;
    put(OTPS_ABOVE, -16'sh0032);
    cyc(100);
    put(OTPS_ABOVE, 16'sh0032);
    cyc(12);
    check(binOut, 1'b1);
    put(OTPS_ABOVE, -16'sh0032);
    cyc(20);
    check(binOut, 1'b1);
    cyc(40);
    check(binOut, 1'b0);
    put(OTPS_ABOVE, 16'sh0032);
    cyc(20);
    check(binOut, 1'b0);
    cyc(80);
    check(binOut, 1'b1);
    @(posedge core_clk);
    minOnTime <= '0;
    minOffTime <= '0;
    // each alarm status through force off, force on and freeze
    for (int k = 1; k < 4; k++) begin
      put(OTPS_ABOVE, 16'sh0032);
      cyc(20);
      @(posedge core_clk);
      alarmReact <= OTPS_IMM_OFF;
      srcStatus <= otps_status_e'(2'(k));
      cyc(3);
      check(binOut, 1'b0);
      check(alarmActive, 1'b1);
      @(posedge core_clk);
      alarmReact <= OTPS_IMM_ON;
      cyc(3);
      check(binOut, 1'b1);
      @(posedge core_clk);
      alarmReact <= OTPS_NO_CHANGE;
      srcValue <= -16'sh0032;
      cyc(20);
      check(binOut, 1'b1);
      @(posedge core_clk);
      srcStatus <= OTPS_ST_OK;
      cyc(20);
      check(binOut, 1'b0);
      check(alarmActive, 1'b0);
    end
    put(OTPS_ABOVE, 16'sh0032);
    cyc(20);
    @(posedge core_clk);
    alarmReact <= OTPS_TIMED_OFF;
    offDelay <= 16'h0005;
    srcStatus <= OTPS_ST_ERROR;
    cyc(12);
    check(binOut, 1'b1);
    cyc(30);
    check(binOut, 1'b0);
    // timed on with the source low: only the alarm can raise the output
    @(posedge core_clk);
    alarmReact <= OTPS_TIMED_ON;
    onDelay <= 16'h0005;
    srcValue <= -16'sh0032;
    cyc(12);
    check(binOut, 1'b0);
    cyc(30);
    check(binOut, 1'b1);
    @(posedge core_clk);
    srcStatus <= OTPS_ST_OK;
    offDelay <= '0;
    onDelay <= '0;
    for (int i = 0; i < 12; i++) begin
      s = otps_val_t'($random(seed) % 1500);
      if (i < 2) s = i ? 16'sh03e8 : 16'sh0000;
      put(OTPS_ABOVE, s);
      cyc(2);
      check(currentOut, curExp(s));
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      srcStatus <= OTPS_ST_ERROR;
      currentAlarm <= caIn[i];
      cyc(2);
      check(currentOut, caExp[i]);
    end
    @(posedge core_clk);
    upperConst <= 16'sh0064;
    pwmAlarmLevel <= 16'sh0046;
    pwmCase(16'sh001e, 16'h0064, OTPS_ST_OK, '0, '0, 240, 2);
    pwmCase(-16'sh0014, 16'h0064, OTPS_ST_OK, '0, '0, 0, 0);
    pwmCase(16'sh0096, 16'h0064, OTPS_ST_OK, '0, '0, 800, 0);
    pwmCase(16'sh001e, 16'h000a, OTPS_ST_OK, '0, '0, 240, 2);
    pwmCase(16'sh001e, 16'h0064, OTPS_ST_ERROR, '0, '0, 560, 2);
    pwmCase(16'sh0002, 16'h0064, OTPS_ST_OK, 16'h0014, '0, -1, 0);
    pwmCase(16'sh0062, 16'h0064, OTPS_ST_OK, '0, 16'h0014, -1, 0);
    summarize();
  end
endmodule : testbench
